// ==== inc/dpec_pkg.sv ====
// Shared constants and state types for the dual probe edge capture block
package dpec_pkg;

   // Object dictionary indices of the probe entries
   localparam logic [15:0] OD_FUNC = 16'h60b8;
   localparam logic [15:0] OD_STATUS = 16'h60b9;
   localparam logic [15:0] OD_P1_RISE_POS = 16'h60ba;
   localparam logic [15:0] OD_P1_FALL_POS = 16'h60bb;
   localparam logic [15:0] OD_P2_RISE_POS = 16'h60bc;
   localparam logic [15:0] OD_P2_FALL_POS = 16'h60bd;
   localparam logic [15:0] OD_SELECT = 16'h60d0;
   localparam logic [15:0] OD_P1_RISE_TIME = 16'h60d1;
   localparam logic [15:0] OD_P1_FALL_TIME = 16'h60d2;
   localparam logic [15:0] OD_P2_RISE_TIME = 16'h60d3;
   localparam logic [15:0] OD_P2_FALL_TIME = 16'h60d4;

   // Sub-index values
   localparam logic [7:0] SUB_COUNT = 8'h00;
   localparam logic [7:0] SUB_PROBE1 = 8'h01;
   localparam logic [7:0] SUB_PROBE2 = 8'h02;
   localparam logic [7:0] SEL_ENTRIES = 8'h02;

   // Function word field positions within one channel's byte
   localparam int unsigned FN_ENABLE_BIT = 0;
   localparam int unsigned FN_MODE_BIT = 1;
   localparam int unsigned FN_SRC_LSB = 2;
   localparam int unsigned FN_RISE_BIT = 4;
   localparam int unsigned FN_FALL_BIT = 5;
   localparam int unsigned CH_STRIDE = 8;
   localparam int unsigned CH_COUNT = 2;

   // Writable bits of the function word; bits 6,7,14,15 stay zero
   localparam logic [15:0] FN_WRITE_MASK = 16'h3f3f;

   // Status word bit positions within one channel's byte
   localparam int unsigned ST_ENABLED_BIT = 0;
   localparam int unsigned ST_RISE_BIT = 1;
   localparam int unsigned ST_FALL_BIT = 2;

   // Trigger source encodings
   localparam logic [1:0] SRC_PIN = 2'h0;
   localparam logic [1:0] SRC_INDEX = 2'h1;
   localparam logic [1:0] SRC_SELECT = 2'h2;

   // Number of digital input pins that a select entry may name
   localparam int unsigned PIN_COUNT = 16;

   // Reset values
   localparam logic [15:0] FUNC_RST = 16'h0000;
   localparam logic [15:0] SEL_RST = 16'h0000;

   // State of one capture channel
   typedef struct packed {
      logic prev;
      logic rise_st;
      logic fall_st;
      logic [31:0] rise_pos;
      logic [31:0] fall_pos;
      logic [31:0] rise_time;
      logic [31:0] fall_time;
   } dpec_chan_t;

   // State of the top level: settings, synchronisers, read answer
   typedef struct packed {
      logic [15:0] func;
      logic [1:0][15:0] sel;
      logic [15:0] pin_m;
      logic [15:0] pin_s;
      logic idx_m;
      logic idx_s;
      logic [31:0] rdata;
      logic ack;
      logic err;
   } dpec_top_t;

endpackage

// ==== design/dpec_channel.sv ====
`timescale 1ns/100ps
`default_nettype none

// One probe channel: edge detection and position/time holders
module dpec_channel
(
   input wire logic clk,
   input wire logic rst,
   input wire logic enable,
   input wire logic continuous,
   input wire logic rise_en,
   input wire logic fall_en,
   input wire logic trig,
   input wire logic [31:0] position,
   input wire logic [31:0] time_ns,
   output logic rise_stored,
   output logic fall_stored,
   output logic [31:0] rise_pos,
   output logic [31:0] fall_pos,
   output logic [31:0] rise_time,
   output logic [31:0] fall_time
);
   import dpec_pkg::*; // Shared constants and state types

   dpec_chan_t s_q; // Registered channel state
   dpec_chan_t s_d; // Next channel state
   logic rise_ev; // Rising edge of the trigger this cycle
   logic fall_ev; // Falling edge of the trigger this cycle

   // Edges seen against last cycle's trigger level
   assign rise_ev = trig & ~s_q.prev;
   assign fall_ev = ~trig & s_q.prev;

   // Next state: capture on qualifying edges, clear the stored flags when off
   always_comb
   begin
      s_d = s_q;
      s_d.prev = trig;
      if (!enable)
      begin
         // Channel off: flags drop, nothing is captured
         s_d.rise_st = 1'b0;
         s_d.fall_st = 1'b0;
      end
      else
      begin
         // Rising edge; in first-event mode only while no rising value is stored
         if (rise_en && rise_ev && (continuous || !s_q.rise_st))
         begin
            s_d.rise_st = 1'b1;
            s_d.rise_pos = position;
            s_d.rise_time = time_ns;
         end
         // Falling edge, same qualification
         if (fall_en && fall_ev && (continuous || !s_q.fall_st))
         begin
            s_d.fall_st = 1'b1;
            s_d.fall_pos = position;
            s_d.fall_time = time_ns;
         end
      end
   end

   // State register
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the holders
   assign rise_stored = s_q.rise_st;
   assign fall_stored = s_q.fall_st;
   assign rise_pos = s_q.rise_pos;
   assign fall_pos = s_q.fall_pos;
   assign rise_time = s_q.rise_time;
   assign fall_time = s_q.fall_time;

endmodule
`default_nettype wire

// ==== design/dpec_top.sv ====
`timescale 1ns/100ps
`default_nettype none

module dpec_top
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic [15:0] OD_INDEX,
   input wire logic [7:0] OD_SUB,
   input wire logic OD_WR,
   input wire logic OD_RD,
   input wire logic [31:0] OD_WDATA,
   output logic [31:0] OD_RDATA,
   output logic OD_ACK,
   output logic OD_ERR,
   input wire logic [15:0] PROBE_PIN,
   input wire logic ENC_INDEX,
   input wire logic [31:0] AXIS_POSITION,
   input wire logic [31:0] TIME_NS
);
   import dpec_pkg::*; // Shared constants and state types

   dpec_top_t s_q; // Registered top state
   dpec_top_t s_d; // Next top state

   // Per-channel trigger levels and results from the capture channels, and the status word
   logic [CH_COUNT-1:0] rise_stored; // Rising value held
   logic [CH_COUNT-1:0] fall_stored; // Falling value held
   logic [CH_COUNT-1:0] trig; // Selected trigger level
   logic [CH_COUNT-1:0][31:0] rise_pos; // Rising positions
   logic [CH_COUNT-1:0][31:0] fall_pos; // Falling positions
   logic [CH_COUNT-1:0][31:0] rise_time; // Rising time stamps
   logic [CH_COUNT-1:0][31:0] fall_time; // Falling time stamps
   logic [15:0] status; // Assembled status word

   // Level of the pin that a select entry names, zero if none
   function automatic logic select_level(input logic [15:0] sel, input logic [15:0] pins);
      logic [15:0] mag;
      logic lvl;
      mag = 16'h0000 - sel;
      lvl = 1'b0;
      // Entry -n names pin n-1 (pins[n-1]); anything else names no pin
      if (mag >= 16'h0001 && mag <= 16'(PIN_COUNT))
      begin
         lvl = pins[4'(mag - 16'h0001)];
      end
      return lvl;
   endfunction

   // Trigger level of one channel from its source field
   function automatic logic src_level(input logic [1:0] src, input logic [15:0] sel,
                                      input logic [15:0] pins, input logic idx,
                                      input logic [3:0] own_pin);
      logic lvl;
      lvl = 1'b0;
      case (src)
         SRC_PIN:
         begin
            // Channel's own input pin
            lvl = pins[own_pin];
         end
         SRC_INDEX:
         begin
            // Encoder index pulse
            lvl = idx;
         end
         SRC_SELECT:
         begin
            // Pin named by the select entry
            lvl = select_level(sel, pins);
         end
         default:
         begin
            // Reserved source: no trigger at all
            lvl = 1'b0;
         end
      endcase
      return lvl;
   endfunction

   // One capture channel per probe with its own configuration byte
   generate
      for (genvar ch = 0; ch < CH_COUNT; ch++)
      begin : g_ch
         // Source choice for this probe
         assign trig[ch] = src_level(s_q.func[ch*CH_STRIDE+FN_SRC_LSB +: 2], s_q.sel[ch],
                                     s_q.pin_s, s_q.idx_s, 4'(ch));

         // Edge capture for this probe
         dpec_channel u_chan (
            .clk(CLK),
            .rst(RST),
            .enable(s_q.func[ch*CH_STRIDE+FN_ENABLE_BIT]),
            .continuous(s_q.func[ch*CH_STRIDE+FN_MODE_BIT]),
            .rise_en(s_q.func[ch*CH_STRIDE+FN_RISE_BIT]),
            .fall_en(s_q.func[ch*CH_STRIDE+FN_FALL_BIT]),
            .trig(trig[ch]),
            .position(AXIS_POSITION),
            .time_ns(TIME_NS),
            .rise_stored(rise_stored[ch]),
            .fall_stored(fall_stored[ch]),
            .rise_pos(rise_pos[ch]),
            .fall_pos(fall_pos[ch]),
            .rise_time(rise_time[ch]),
            .fall_time(fall_time[ch])
         );
      end
   endgenerate

   // Status word: enable and stored flags, reserved bits zero
   always_comb
   begin
      status = 16'h0000;
      for (int ch = 0; ch < CH_COUNT; ch++)
      begin
         status[ch*CH_STRIDE+ST_ENABLED_BIT] = s_q.func[ch*CH_STRIDE+FN_ENABLE_BIT];
         // Flags are masked by the enable so a switched-off probe never shows a stale flag
         status[ch*CH_STRIDE+ST_RISE_BIT] = rise_stored[ch] & s_q.func[ch*CH_STRIDE+FN_ENABLE_BIT];
         status[ch*CH_STRIDE+ST_FALL_BIT] = fall_stored[ch] & s_q.func[ch*CH_STRIDE+FN_ENABLE_BIT];
      end
   end

   // Next state: synchronisers, dictionary writes and read answers
   always_comb
   begin
      s_d = s_q;

      // Two-stage synchronisers for the pins and the index
      s_d.pin_m = PROBE_PIN;
      s_d.pin_s = s_q.pin_m;
      s_d.idx_m = ENC_INDEX;
      s_d.idx_s = s_q.idx_m;

      // Answer strobes last one cycle
      s_d.ack = OD_WR | OD_RD;
      s_d.err = 1'b0;

      if (OD_WR)
      begin
         // Writes reach only the function word and the select entries
         if (OD_INDEX == OD_FUNC && OD_SUB == SUB_COUNT)
         begin
            s_d.func = OD_WDATA[15:0] & FN_WRITE_MASK;
         end
         else if (OD_INDEX == OD_SELECT && OD_SUB == SUB_PROBE1)
         begin
            s_d.sel[0] = OD_WDATA[15:0];
         end
         else if (OD_INDEX == OD_SELECT && OD_SUB == SUB_PROBE2)
         begin
            s_d.sel[1] = OD_WDATA[15:0];
         end
         else
         begin
            // Read-only or unknown entry
            s_d.err = 1'b1;
         end
      end
      else if (OD_RD)
      begin
         // Read answer, registered for the next cycle
         s_d.rdata = 32'h00000000;
         if (OD_INDEX == OD_SELECT)
         begin
            case (OD_SUB)
               SUB_COUNT:
               begin
                  // Count of entries that follow
                  s_d.rdata = {24'h000000, SEL_ENTRIES};
               end
               SUB_PROBE1:
               begin
                  // Sign-extended entry one
                  s_d.rdata = {{16{s_q.sel[0][15]}}, s_q.sel[0]};
               end
               SUB_PROBE2:
               begin
                  // Sign-extended entry two
                  s_d.rdata = {{16{s_q.sel[1][15]}}, s_q.sel[1]};
               end
               default:
               begin
                  // No such sub-index
                  s_d.err = 1'b1;
               end
            endcase
         end
         else if (OD_SUB != SUB_COUNT)
         begin
            // Scalar entries have only sub-index zero
            s_d.err = 1'b1;
         end
         else
         begin
            case (OD_INDEX)
               OD_FUNC:
               begin
                  // Function word
                  s_d.rdata = {16'h0000, s_q.func};
               end
               OD_STATUS:
               begin
                  // Status word
                  s_d.rdata = {16'h0000, status};
               end
               OD_P1_RISE_POS:
               begin
                  // Probe one rising position
                  s_d.rdata = rise_pos[0];
               end
               OD_P1_FALL_POS:
               begin
                  // Probe one falling position
                  s_d.rdata = fall_pos[0];
               end
               OD_P2_RISE_POS:
               begin
                  // Probe two rising position
                  s_d.rdata = rise_pos[1];
               end
               OD_P2_FALL_POS:
               begin
                  // Probe two falling position
                  s_d.rdata = fall_pos[1];
               end
               OD_P1_RISE_TIME:
               begin
                  // Probe one rising time
                  s_d.rdata = rise_time[0];
               end
               OD_P1_FALL_TIME:
               begin
                  // Probe one falling time
                  s_d.rdata = fall_time[0];
               end
               OD_P2_RISE_TIME:
               begin
                  // Probe two rising time
                  s_d.rdata = rise_time[1];
               end
               OD_P2_FALL_TIME:
               begin
                  // Probe two falling time
                  s_d.rdata = fall_time[1];
               end
               default:
               begin
                  // Unknown entry
                  s_d.err = 1'b1;
               end
            endcase
         end
      end
   end

   // State register
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         s_q <= '0;
         s_q.func <= FUNC_RST;
         s_q.sel[0] <= SEL_RST;
         s_q.sel[1] <= SEL_RST;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // Dictionary answer from registers
   assign OD_RDATA = s_q.rdata;
   assign OD_ACK = s_q.ack;
   assign OD_ERR = s_q.err;

endmodule
`default_nettype wire

// ==== test/dpec_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
// Watches the dictionary port of the probe block
module dpec_monitor
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic [15:0] OD_INDEX,
   input wire logic [7:0] OD_SUB,
   input wire logic OD_WR,
   input wire logic OD_RD,
   input wire logic [31:0] OD_WDATA,
   input wire logic [31:0] OD_RDATA,
   input wire logic OD_ACK,
   input wire logic OD_ERR,
   input wire logic [15:0] PROBE_PIN,
   input wire logic ENC_INDEX,
   input wire logic [31:0] AXIS_POSITION,
   input wire logic [31:0] TIME_NS
);
   import dpec_pkg::*;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   // Plain reads and writes of single objects
   logic rd_st;
   logic rd_fn;
   logic wr_fn;
   logic [1:0] wd_en;
   assign rd_st = OD_RD && !OD_WR && OD_INDEX == OD_STATUS && OD_SUB == SUB_COUNT;
   assign rd_fn = OD_RD && !OD_WR && OD_INDEX == OD_FUNC && OD_SUB == SUB_COUNT;
   assign wr_fn = OD_WR && OD_INDEX == OD_FUNC && OD_SUB == SUB_COUNT;
   assign wd_en = {OD_WDATA[8], OD_WDATA[0]};
   // Every request is answered on the next edge, and only then
   a_ack_answer: assert property ((OD_WR || OD_RD) |=> OD_ACK) else $error("request not answered");
   a_ack_cause: assert property (OD_ACK |-> $past(OD_WR || OD_RD)) else $error("answer without request");
   a_err_ack: assert property (OD_ERR |-> OD_ACK) else $error("error without answer");
   // Refused accesses, and the accepted select count read
   a_ro_refused: assert property (OD_WR && OD_INDEX == OD_STATUS |=> OD_ERR)
      else $error("status write accepted");
   a_sel_range: assert property (OD_RD && !OD_WR && OD_INDEX == OD_SELECT && OD_SUB > SEL_ENTRIES
      |=> OD_ERR && OD_RDATA == 32'h0) else $error("bad select sub accepted");
   a_sel_count: assert property (OD_RD && !OD_WR && OD_INDEX == OD_SELECT && OD_SUB == SUB_COUNT
      |=> OD_RDATA == 32'h2 && !OD_ERR) else $error("select count wrong");
   // Read data only moves on a read answer
   a_rdata_hold: assert property (!$past(OD_RD) |-> $stable(OD_RDATA)) else $error("read data moved");
   a_fn_reserved: assert property (rd_fn |=> OD_RDATA[15:14] == 2'h0 && OD_RDATA[7:6] == 2'h0)
      else $error("function reserved bits set");
   a_st_reserved: assert property (rd_st |=> OD_RDATA[7:3] == 5'h0 && OD_RDATA[15:11] == 5'h0)
      else $error("status reserved bits set");
   a_off_no_flags: assert property (rd_st |=> (OD_RDATA[0] || OD_RDATA[2:1] == 2'h0)
      && (OD_RDATA[8] || OD_RDATA[10:9] == 2'h0)) else $error("flag on disabled probe");
   a_enable_shown: assert property (wr_fn ##1 !OD_WR ##1 rd_st
      |=> {OD_RDATA[8], OD_RDATA[0]} == $past(wd_en, 3)) else $error("enable not shown");
   // Main scenarios
   c_rise_flag: cover property (rd_st ##1 OD_RDATA[1]);
   c_fall_flag: cover property (rd_st ##1 OD_RDATA[10]);
   c_refused: cover property (OD_ERR);
endmodule
bind dpec_top dpec_monitor mon (.CLK(CLK), .RST(RST), .OD_INDEX(OD_INDEX), .OD_SUB(OD_SUB),
   .OD_WR(OD_WR), .OD_RD(OD_RD), .OD_WDATA(OD_WDATA), .OD_RDATA(OD_RDATA), .OD_ACK(OD_ACK),
   .OD_ERR(OD_ERR), .PROBE_PIN(PROBE_PIN), .ENC_INDEX(ENC_INDEX), .AXIS_POSITION(AXIS_POSITION),
   .TIME_NS(TIME_NS));
`default_nettype wire

// ==== test/dpec_probe_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// Digital probe pins and encoder index seen by the block
module dpec_probe_model
(
   input wire logic clk,
   output logic [15:0] pins,
   output logic idx
);
   // All lines idle low
   initial
   begin
      pins = 16'h0000;
      idx = 1'b0;
   end
   // Moves one line (16 is the index) at this edge, holds it for hold cycles
   task automatic set_line(input int n, input logic v, input int hold);
      if (n == 16)
         idx <= v;
      else
         pins[n] <= v;
      repeat (hold) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench for the probe capture block
module tb_top;
   import dpec_pkg::*;
   logic CLK = 1'b0;
   logic RST = 1'b1;
   logic [15:0] OD_INDEX = 16'h0000;
   logic [7:0] OD_SUB = 8'h00;
   logic OD_WR = 1'b0;
   logic OD_RD = 1'b0;
   logic [31:0] OD_WDATA = 32'h0;
   logic [31:0] OD_RDATA;
   logic OD_ACK;
   logic OD_ERR;
   wire logic [15:0] PROBE_PIN;
   wire logic ENC_INDEX;
   logic [31:0] tm = 32'h0;
   logic [31:0] pos;
   logic [31:0] d;
   logic [31:0] tk [4];
   int n_errors = 0;
   int n_checks = 0;
   // Clock, nanosecond time base and a falling signed position
   always #20 CLK = ~CLK;
   always @(posedge CLK) tm <= tm + 32'h28;
   assign pos = 32'hfff0_0000 - tm;
   dpec_top dut (.CLK(CLK), .RST(RST), .OD_INDEX(OD_INDEX), .OD_SUB(OD_SUB), .OD_WR(OD_WR),
      .OD_RD(OD_RD), .OD_WDATA(OD_WDATA), .OD_RDATA(OD_RDATA), .OD_ACK(OD_ACK), .OD_ERR(OD_ERR),
      .PROBE_PIN(PROBE_PIN), .ENC_INDEX(ENC_INDEX), .AXIS_POSITION(pos), .TIME_NS(tm));
   dpec_probe_model pm (.clk(CLK), .pins(PROBE_PIN), .idx(ENC_INDEX));
   // Compares a data value
   task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   // Compares a handshake flag
   task automatic chk_bit(input string what, input logic exp, input logic got);
      n_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected %s: expected %b, seen %b", what, exp, got);
      end
   endtask
   // One access, started at an edge, ending at the answer edge
   task automatic od_acc(input logic is_wr, input logic [15:0] idx, input logic [7:0] sub,
      input logic [31:0] wd, input logic exp_err);
      OD_WR <= is_wr;
      OD_RD <= !is_wr;
      OD_INDEX <= idx;
      OD_SUB <= sub;
      OD_WDATA <= wd;
      @(posedge CLK);
      OD_WR <= 1'b0;
      OD_RD <= 1'b0;
      @(posedge CLK);
      chk_bit("ack", 1'b1, OD_ACK);
      chk_bit("err", exp_err, OD_ERR);
      d = OD_RDATA;
   endtask
   // Reads one object and compares it
   task automatic rd_chk(input string what, input logic [15:0] idx, input logic [7:0] sub,
      input logic [31:0] exp);
      od_acc(1'b0, idx, sub, 32'h0, 1'b0);
      chk_val(what, exp, d);
   endtask
   // First-event capture on one probe and source, then switch-off
   task automatic run_case(input int ch, input int src);
      int n;
      logic [31:0] t_r;
      logic [31:0] t_f;
      logic [15:0] pb;
      logic [15:0] tb;
      n = (src == 0) ? ch : (src == 1) ? 16 : 2 + 2 * ch;
      pb = ch ? OD_P2_RISE_POS : OD_P1_RISE_POS;
      tb = ch ? OD_P2_RISE_TIME : OD_P1_RISE_TIME;
      od_acc(1'b1, OD_FUNC, SUB_COUNT, 32'(16'h0031 | 16'(src << 2)) << (8 * ch), 1'b0);
      pm.set_line(n, 1'b1, 4);
      // Capture fell one edge back and took the time base of the cycle before it
      t_r = tm - 32'h28;
      rd_chk("status rise", OD_STATUS, SUB_COUNT, 32'h3 << (8 * ch));
      pm.set_line(n, 1'b0, 4);
      t_f = tm - 32'h28;
      pm.set_line(n, 1'b1, 4);
      rd_chk("status both", OD_STATUS, SUB_COUNT, 32'h7 << (8 * ch));
      rd_chk("rise pos", pb, SUB_COUNT, 32'hfff0_0000 - t_r);
      rd_chk("fall pos", pb + 16'h1, SUB_COUNT, 32'hfff0_0000 - t_f);
      rd_chk("rise time", tb, SUB_COUNT, t_r);
      rd_chk("fall time", tb + 16'h1, SUB_COUNT, t_f);
      od_acc(1'b1, OD_FUNC, SUB_COUNT, 32'h0, 1'b0);
      pm.set_line(n, 1'b0, 4);
      rd_chk("status off", OD_STATUS, SUB_COUNT, 32'h0);
      rd_chk("time kept", tb, SUB_COUNT, t_r);
   endtask
   // Prints the counts and the verdict, then stops
   task automatic print_verdict;
      $display("checks %0d, errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Watchdog against a hung handshake
   initial
   begin
      repeat (5000) @(posedge CLK);
      n_errors++;
      print_verdict;
   end
   // Main sequence
   initial
   begin
      repeat (3) @(posedge CLK);
      RST <= 1'b0;
      @(posedge CLK);
      rd_chk("func reset", OD_FUNC, SUB_COUNT, 32'h0);
      rd_chk("status reset", OD_STATUS, SUB_COUNT, 32'h0);
      rd_chk("select count", OD_SELECT, SUB_COUNT, 32'h2);
      od_acc(1'b1, OD_STATUS, SUB_COUNT, 32'h1, 1'b1);
      od_acc(1'b0, 16'h1234, SUB_COUNT, 32'h0, 1'b1);
      chk_val("unmapped", 32'h0, d);
      od_acc(1'b0, OD_SELECT, 8'h03, 32'h0, 1'b1);
      od_acc(1'b1, OD_FUNC, SUB_COUNT, 32'hffff, 1'b0);
      rd_chk("status all on", OD_STATUS, SUB_COUNT, 32'h0101);
      rd_chk("func mask", OD_FUNC, SUB_COUNT, 32'h3f3f);
      od_acc(1'b1, OD_FUNC, SUB_COUNT, 32'h0, 1'b0);
      od_acc(1'b1, OD_SELECT, SUB_PROBE1, 32'hfffd, 1'b0);
      od_acc(1'b1, OD_SELECT, SUB_PROBE2, 32'hfffb, 1'b0);
      rd_chk("select one", OD_SELECT, SUB_PROBE1, 32'hffff_fffd);
      // Reserved source never triggers, whatever its pin does
      od_acc(1'b1, OD_FUNC, SUB_COUNT, 32'h003d, 1'b0);
      pm.set_line(0, 1'b1, 4);
      pm.set_line(0, 1'b0, 4);
      rd_chk("status reserved src", OD_STATUS, SUB_COUNT, 32'h1);
      od_acc(1'b1, OD_FUNC, SUB_COUNT, 32'h0, 1'b0);
      for (int ch = 0; ch < 2; ch++)
         for (int src = 0; src < 3; src++)
            run_case(ch, src);
      // Continuous mode with one polarity gated off
      for (int p = 0; p < 2; p++)
      begin
         od_acc(1'b1, OD_FUNC, SUB_COUNT, p ? 32'h0023 : 32'h0013, 1'b0);
         for (int k = 0; k < 4; k++)
         begin
            pm.set_line(0, !k[0], 4);
            tk[k] = tm - 32'h28;
         end
         rd_chk("status gated", OD_STATUS, SUB_COUNT, p ? 32'h5 : 32'h3);
         rd_chk("last time", p ? OD_P1_FALL_TIME : OD_P1_RISE_TIME, SUB_COUNT, tk[2 + p]);
         od_acc(1'b1, OD_FUNC, SUB_COUNT, 32'h0, 1'b0);
      end
      print_verdict;
   end
endmodule
`default_nettype wire
